// ---- hw/asx_flags.sv ----
// Arithmetic status, sticky status and exception request logic for two elements.
// Assumes unit flag inputs are one-cycle results valid with their op strobes,
// and an Avalon-MM master that holds requests until waitrequest is low.
`timescale 1ns/1ps
`include "asx_defines.svh"

module asx_flags #(
  parameter int NPE = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Mode
  input wire logic simd_en_i,
  // ALU result flags, bit 0 = element x, bit 1 = element y
  input wire logic [NPE-1:0] alu_op_i,
  input wire logic [NPE-1:0] alu_float_i,
  input wire logic [NPE-1:0] alu_zero_i,
  input wire logic [NPE-1:0] alu_ovf_i,
  input wire logic [NPE-1:0] alu_neg_i,
  input wire logic [NPE-1:0] alu_carry_i,
  input wire logic [NPE-1:0] alu_xsign_i,
  input wire logic [NPE-1:0] alu_inv_i,
  input wire logic [NPE-1:0] alu_cmp_i,
  input wire logic [NPE-1:0] alu_cmp_gt_i,
  // Multiplier result flags
  input wire logic [NPE-1:0] mul_op_i,
  input wire logic [NPE-1:0] mul_float_i,
  input wire logic [NPE-1:0] mul_neg_i,
  input wire logic [NPE-1:0] mul_ovf_i,
  input wire logic [NPE-1:0] mul_unf_i,
  input wire logic [NPE-1:0] mul_inv_i,
  // Shifter result flags
  input wire logic [NPE-1:0] sh_op_i,
  input wire logic [NPE-1:0] sh_ovf_i,
  input wire logic [NPE-1:0] sh_zero_i,
  input wire logic [NPE-1:0] sh_sign_i,
  input wire logic [NPE-1:0] sh_fifo_i,
  // Exception requests to the sequencer, indexed by asx_pkg::asx_vec_t
  input wire logic [3:0] exc_enable_i,
  output logic [3:0] exc_req_o
);
  import asx_pkg::*;

  logic [31:0] stat_q [NPE];
  logic [31:0] stky_q [NPE];
  logic [3:0] exc_q [NPE];
  logic [3:0] exc_req_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic wait_q;

  // One wait cycle per access keeps the read path registered
  logic req;
  logic acc;
  assign req = avs_read_i | avs_write_i;
  assign acc = req & ~ack_q;

  logic [31:0] bmask;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // Waitrequest has its own flop so the pin never sees an inverter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~acc;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPE; p++) begin : g_pe
      logic wr_stat;
      logic wr_stky;
      logic act_y;
      logic [31:0] stat_d;
      logic [31:0] stky_set;
      logic [31:0] wval_stat;
      logic [31:0] wval_stky;
      // Element y only reports while SIMD is on
      assign act_y = (p == 0) | simd_en_i;
      assign wr_stat = avs_write_i & ack_q &
                       (avs_address_i == (p == 0 ? `ASX_OFF_STAT_X : `ASX_OFF_STAT_Y));
      assign wr_stky = avs_write_i & ack_q &
                       (avs_address_i == (p == 0 ? `ASX_OFF_STKY_X : `ASX_OFF_STKY_Y));
      assign wval_stat = (stat_q[p] & ~bmask) | (avs_writedata_i & bmask);
      assign wval_stky = (stky_q[p] & ~bmask) | (avs_writedata_i & bmask);

      always_comb begin
        stat_d = stat_q[p];
        stky_set = 32'h0000_0000;
        if (alu_op_i[p] & act_y) begin
          stat_d[`ASX_B_ALU_ZERO] = alu_zero_i[p];
          stat_d[`ASX_B_ALU_OVF] = alu_ovf_i[p];
          stat_d[`ASX_B_ALU_NEG] = alu_neg_i[p];
          stat_d[`ASX_B_ALU_CARRY] = alu_carry_i[p] & ~alu_float_i[p];
          stat_d[`ASX_B_ALU_XSIGN] = alu_xsign_i[p];
          stat_d[`ASX_B_ALU_INV] = alu_inv_i[p] & alu_float_i[p];
          stat_d[`ASX_B_ALU_FLOAT] = alu_float_i[p];
          // compare history shifts in newest at top
          if (alu_cmp_i[p]) begin
            stat_d[`ASX_B_CMP_HI:`ASX_B_CMP_LO] =
              {alu_cmp_gt_i[p], stat_q[p][`ASX_B_CMP_HI:`ASX_B_CMP_LO+1]};
          end
          stky_set[`ASX_S_ALU_UNF] = alu_zero_i[p] & alu_float_i[p];
          stky_set[`ASX_S_ALU_FOVF] = alu_ovf_i[p] & alu_float_i[p];
          stky_set[`ASX_S_ALU_XOVF] = alu_ovf_i[p] & ~alu_float_i[p];
          stky_set[`ASX_S_ALU_INV] = alu_inv_i[p] & alu_float_i[p];
        end
        if (mul_op_i[p] & act_y) begin
          stat_d[`ASX_B_MUL_NEG] = mul_neg_i[p];
          stat_d[`ASX_B_MUL_OVF] = mul_ovf_i[p];
          stat_d[`ASX_B_MUL_UNF] = mul_unf_i[p];
          stat_d[`ASX_B_MUL_INV] = mul_inv_i[p] & mul_float_i[p];
          stky_set[`ASX_S_MUL_XOVF] = mul_ovf_i[p] & ~mul_float_i[p];
          stky_set[`ASX_S_MUL_FOVF] = mul_ovf_i[p] & mul_float_i[p];
          stky_set[`ASX_S_MUL_UNF] = mul_unf_i[p];
          stky_set[`ASX_S_MUL_INV] = mul_inv_i[p] & mul_float_i[p];
        end
        if (sh_op_i[p] & act_y) begin
          stat_d[`ASX_B_SH_OVF] = sh_ovf_i[p];
          stat_d[`ASX_B_SH_ZERO] = sh_zero_i[p];
          stat_d[`ASX_B_SH_SIGN] = sh_sign_i[p];
          stat_d[`ASX_B_SH_FIFO] = sh_fifo_i[p];
        end
      end

      // commit next cycle, software write wins
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stat_q[p] <= `ASX_STAT_RST;
        end else if (wr_stat) begin
          stat_q[p] <= wval_stat;
        end else begin
          stat_q[p] <= stat_d;
        end
      end

      // sticky is held OR new; no clear on return
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stky_q[p] <= `ASX_STKY_RST;
        end else if (wr_stky) begin
          stky_q[p] <= wval_stky;
        end else begin
          stky_q[p] <= stky_q[p] | stky_set;
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          exc_q[p] <= 4'h0;
        end else begin
          exc_q[p][ASX_VEC_FIXED_OVF] <= stky_set[`ASX_S_ALU_XOVF] | stky_set[`ASX_S_MUL_XOVF];
          exc_q[p][ASX_VEC_FLOAT_OVF] <= stky_set[`ASX_S_ALU_FOVF] | stky_set[`ASX_S_MUL_FOVF];
          exc_q[p][ASX_VEC_FLOAT_UNF] <= stky_set[`ASX_S_ALU_UNF] | stky_set[`ASX_S_MUL_UNF];
          exc_q[p][ASX_VEC_FLOAT_INV] <= stky_set[`ASX_S_ALU_INV] | stky_set[`ASX_S_MUL_INV];
        end
      end
    end
  endgenerate

  // OR of elements, one line per vector, two cycles late
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exc_req_q <= 4'h0;
    end else begin
      exc_req_q <= (exc_q[0] | exc_q[1]) & exc_enable_i;
    end
  end
  assign exc_req_o = exc_req_q;

  // Read data registered in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc & avs_read_i) begin
      unique case (avs_address_i)
        `ASX_OFF_STAT_X: rdata_q <= stat_q[0];
        `ASX_OFF_STAT_Y: rdata_q <= stat_q[1];
        `ASX_OFF_STKY_X: rdata_q <= stky_q[0];
        `ASX_OFF_STKY_Y: rdata_q <= stky_q[1];
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // Assertions
  logic sw_wr;
  assign sw_wr = avs_write_i & ack_q;
  chk_stky_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(stky_q[0][`ASX_S_ALU_XOVF]) && !$past(sw_wr)
    |-> stky_q[0][`ASX_S_ALU_XOVF]) else $error("sticky bit dropped");
  chk_alu_fix_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_ovf_i[0] && !alu_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_ALU_XOVF]) else $error("fixed overflow sticky missing");
  chk_mul_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && mul_unf_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_MUL_UNF]) else $error("mul underflow sticky missing");
  chk_alu_float: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_ALU_FLOAT] == $past(alu_float_i[0])) else $error("float marker wrong");
  chk_alu_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_ALU_ZERO] == $past(alu_zero_i[0])) else $error("zero flag wrong");
  chk_alu_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_ALU_OVF] == $past(alu_ovf_i[0])) else $error("overflow flag wrong");
  chk_alu_neg: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_ALU_NEG] == $past(alu_neg_i[0])) else $error("negative flag wrong");
  chk_alu_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr |=> stat_q[0][`ASX_B_ALU_CARRY] ==
    $past(alu_carry_i[0] && !alu_float_i[0])) else $error("carry flag wrong");
  chk_alu_inv: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && !sw_wr |=> stat_q[0][`ASX_B_ALU_INV] ==
    $past(alu_inv_i[0] && alu_float_i[0])) else $error("invalid flag wrong");
  chk_cmp_newest: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_cmp_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_CMP_HI] == $past(alu_cmp_gt_i[0])) else $error("compare newest wrong");
  chk_cmp_age: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_cmp_i[0] && !sw_wr
    |=> stat_q[0][30:24] == $past(stat_q[0][31:25])) else $error("compare history wrong");
  chk_flt_ovf_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_ovf_i[0] && alu_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_ALU_FOVF]) else $error("float overflow sticky missing");
  chk_alu_unf_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_zero_i[0] && alu_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_ALU_UNF]) else $error("underflow sticky missing");
  chk_alu_inv_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_inv_i[0] && alu_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_ALU_INV]) else $error("invalid sticky missing");
  chk_mul_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_MUL_OVF] == $past(mul_ovf_i[0])) else $error("mul overflow wrong");
  chk_mul_unf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_MUL_UNF] == $past(mul_unf_i[0])) else $error("mul underflow wrong");
  chk_mul_fix_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && mul_ovf_i[0] && !mul_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_MUL_XOVF]) else $error("mul fixed sticky missing");
  chk_mul_inv_stky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && mul_inv_i[0] && mul_float_i[0] && !sw_wr
    |=> stky_q[0][`ASX_S_MUL_INV]) else $error("mul invalid sticky missing");
  chk_sh_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sh_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_SH_ZERO] == $past(sh_zero_i[0])) else $error("shift zero wrong");
  chk_sh_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sh_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_SH_OVF] == $past(sh_ovf_i[0])) else $error("shift overflow wrong");
  chk_sh_sign: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sh_op_i[0] && !sw_wr
    |=> stat_q[0][`ASX_B_SH_SIGN] == $past(sh_sign_i[0])) else $error("shift sign wrong");
  chk_y_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !simd_en_i && !sw_wr |=> stat_q[1] == $past(stat_q[1]) &&
    stky_q[1] == $past(stky_q[1])) else $error("element y moved outside SIMD");
  chk_y_exc: assert property (@(posedge clk_i) disable iff (!rstn_i)
    simd_en_i && alu_op_i[1] && alu_ovf_i[1] && alu_float_i[1] && exc_enable_i[1]
    ##1 exc_enable_i[1] |=> exc_req_o[1]) else $error("element y exception lost");
  chk_stky_keep_x: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(sw_wr) |-> (stky_q[0] & $past(stky_q[0])) == $past(stky_q[0]))
    else $error("sticky x cleared by hardware");
  chk_stky_keep_y: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(sw_wr) |-> (stky_q[1] & $past(stky_q[1])) == $past(stky_q[1]))
    else $error("sticky y cleared by hardware");
  chk_req_enabled: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exc_req_o[1] |-> $past(exc_enable_i[1])) else $error("masked exception raised");
  chk_unf_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_zero_i[0] && alu_float_i[0] && exc_enable_i[2]
    ##1 exc_enable_i[2] |=> exc_req_o[2]) else $error("underflow not routed");
  chk_inv_route: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mul_op_i[0] && mul_inv_i[0] && mul_float_i[0] && exc_enable_i[3]
    ##1 exc_enable_i[3] |=> exc_req_o[3]) else $error("invalid not routed");
  chk_stat_wr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sw_wr && avs_address_i == `ASX_OFF_STAT_X && avs_byteenable_i[3]
    |=> stat_q[0][31:24] == $past(avs_writedata_i[31:24])) else $error("status write lost");
  chk_wait_one: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  chk_exc_delay: assert property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_ovf_i[0] && !alu_float_i[0] && exc_enable_i[0]
    ##1 exc_enable_i[0] |=> exc_req_o[0]) else $error("exception not raised");
  chk_no_shift_exc: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ($past(alu_op_i, 2) == 2'b00) && ($past(mul_op_i, 2) == 2'b00)
    |-> exc_req_o == 4'h0) else $error("exception without ALU or mul");
  chk_sw_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
    avs_write_i && ack_q && avs_address_i == `ASX_OFF_STKY_X && avs_byteenable_i[0]
    |=> stky_q[0][7:0] == $past(avs_writedata_i[7:0])) else $error("write lost");
  cov_exc: cover property (@(posedge clk_i) disable iff (!rstn_i) exc_req_o != 4'h0);
  cov_simd_y: cover property (@(posedge clk_i) disable iff (!rstn_i)
    simd_en_i && alu_op_i[1] && alu_ovf_i[1]);
  cov_clear: cover property (@(posedge clk_i) disable iff (!rstn_i)
    avs_write_i && ack_q && avs_address_i == `ASX_OFF_STKY_Y);
  cov_cmp: cover property (@(posedge clk_i) disable iff (!rstn_i)
    alu_op_i[0] && alu_cmp_i[0]);
endmodule

// ---- hw/asx_defines.svh ----
// Offsets, field positions and reset values for the arithmetic status block.
// Assumes an Avalon-MM slave with word addressing in bytes, 32-bit data.
`ifndef ASX_DEFINES_SVH
`define ASX_DEFINES_SVH

// Register byte offsets
`define ASX_OFF_STAT_X 4'h0
`define ASX_OFF_STAT_Y 4'h4
`define ASX_OFF_STKY_X 4'h8
`define ASX_OFF_STKY_Y 4'hC
`define ASX_OFF_CTRL 4'h0

// Arithmetic status fields
`define ASX_B_ALU_ZERO 0
`define ASX_B_ALU_OVF 1
`define ASX_B_ALU_NEG 2
`define ASX_B_ALU_CARRY 3
`define ASX_B_ALU_XSIGN 4
`define ASX_B_ALU_INV 5
`define ASX_B_MUL_NEG 6
`define ASX_B_MUL_OVF 7
`define ASX_B_MUL_UNF 8
`define ASX_B_MUL_INV 9
`define ASX_B_ALU_FLOAT 10
`define ASX_B_SH_OVF 11
`define ASX_B_SH_ZERO 12
`define ASX_B_SH_SIGN 13
`define ASX_B_SH_FIFO 14
`define ASX_B_CMP_LO 24
`define ASX_B_CMP_HI 31

// Sticky fields
`define ASX_S_ALU_UNF 0
`define ASX_S_ALU_FOVF 1
`define ASX_S_ALU_XOVF 2
`define ASX_S_ALU_INV 5
`define ASX_S_MUL_XOVF 6
`define ASX_S_MUL_FOVF 7
`define ASX_S_MUL_UNF 8
`define ASX_S_MUL_INV 9

// Reset values
`define ASX_STAT_RST 32'h0000_0000
`define ASX_STKY_RST 32'h0000_0000

`endif

// ---- hw/asx_pkg.sv ----
// Types for the arithmetic status and exception block.
// Assumes nothing beyond the defines header.
package asx_pkg;
  // Exception vector index within the group of four
  typedef enum logic [1:0] {
    ASX_VEC_FIXED_OVF = 2'h0,
    ASX_VEC_FLOAT_OVF = 2'h1,
    ASX_VEC_FLOAT_UNF = 2'h2,
    ASX_VEC_FLOAT_INV = 2'h3
  } asx_vec_t;
  typedef logic [31:0] asx_word_t;
endpackage

// ---- test/asx_seq_model.sv ----
// Sequencer side model: counts exception requests per vector.
// Assumes one-cycle request pulses on the core clock.
`timescale 1ns/1ps
module asx_seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Requests and observed state
  input wire logic [3:0] exc_req_i,
  output logic [15:0] hits_o [4],
  output logic [5:0] prio_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hits_o <= '{default: '0};
      prio_o <= 6'h00;
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (exc_req_i[i]) begin
          hits_o[i] <= hits_o[i] + 16'h0001;
          // priorities 33 up, lowest vector wins
          prio_o <= 6'h21 + 6'(i);
        end
      end
    end
  end
endmodule

// ---- test/arith_status_exception_flags_bench.sv ----
// Self-checking bench for the status and exception flag block.
// Assumes the one-wait-cycle Avalon slave and the flag timing of the block.
`timescale 1ns/1ps
`include "asx_defines.svh"
module arith_status_exception_flags_bench;
  import asx_pkg::*;
  logic clk_i = 0, rstn_i = 0, simd_en = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, exc_enable = 4'h0, exc_req;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [9:0][1:0] alu = '0, na;
  logic [5:0][1:0] mul = '0, nm;
  logic [4:0][1:0] sh = '0, ns;
  logic [15:0] hits [4];
  asx_word_t mdl [4] = '{default: '0};
  string nm_reg [4] = '{"arith_status_x", "arith_status_y", "sticky_status_x", "sticky_status_y"};
  int exp_hits [4] = '{default: 0};
  int error_cnt = 0, n_compared = 0, seed = 37;
  logic [3:0] ev;
  always #2.5 clk_i = ~clk_i;
  asx_flags u_asx_flags (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .simd_en_i(simd_en),
    .alu_op_i(alu[0]), .alu_float_i(alu[1]), .alu_zero_i(alu[2]), .alu_ovf_i(alu[3]),
    .alu_neg_i(alu[4]), .alu_carry_i(alu[5]), .alu_xsign_i(alu[6]), .alu_inv_i(alu[7]),
    .alu_cmp_i(alu[8]), .alu_cmp_gt_i(alu[9]), .mul_op_i(mul[0]), .mul_float_i(mul[1]),
    .mul_neg_i(mul[2]), .mul_ovf_i(mul[3]), .mul_unf_i(mul[4]), .mul_inv_i(mul[5]),
    .sh_op_i(sh[0]), .sh_ovf_i(sh[1]), .sh_zero_i(sh[2]), .sh_sign_i(sh[3]),
    .sh_fifo_i(sh[4]), .exc_enable_i(exc_enable), .exc_req_o(exc_req));
  asx_seq_model u_asx_seq_model (.clk_i(clk_i), .rstn_i(rstn_i), .exc_req_i(exc_req),
    .hits_o(hits), .prio_o());
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [3:0] b);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      check("waitrequest", 32'h0, 32'(avs_waitrequest));
      conclude();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(int i, logic [31:0] d, logic [3:0] b);
    bus(1'b1, 4'(i * 4), d, b);
    for (int k = 0; k < 4; k++) if (b[k]) mdl[i][k*8+:8] = d[k*8+:8];
  endtask
  task automatic rdchk(int i);
    bus(1'b0, 4'(i * 4), 32'h0, 4'hF);
    check(nm_reg[i], mdl[i], q);
  endtask
  // Applies one element's unit flags to the expected registers
  function automatic logic [3:0] upd(int e);
    logic [3:0] v;
    v = '0;
    if (na[0][e]) begin
      mdl[e][5:0] = {na[7][e], na[6][e], na[5][e] & !na[1][e], na[4][e], na[3][e], na[2][e]};
      mdl[e][`ASX_B_ALU_FLOAT] = na[1][e];
      if (na[8][e]) mdl[e][31:24] = {na[9][e], mdl[e][31:25]};
      v |= {na[7][e], na[2][e] & na[1][e], na[3][e] & na[1][e], na[3][e] & !na[1][e]};
      mdl[2+e] |= {na[7][e], 2'h0, na[3][e] & !na[1][e], na[3][e] & na[1][e],
        na[2][e] & na[1][e]};
    end
    if (nm[0][e]) begin
      mdl[e][9:6] = {nm[5][e], nm[4][e], nm[3][e], nm[2][e]};
      v |= {nm[5][e], nm[4][e], nm[3][e] & nm[1][e], nm[3][e] & !nm[1][e]};
      mdl[2+e][9:6] |= {nm[5][e], nm[4][e], nm[3][e] & nm[1][e], nm[3][e] & !nm[1][e]};
    end
    if (ns[0][e]) mdl[e][14:11] = {ns[4][e], ns[3][e], ns[2][e], ns[1][e]};
    return v;
  endfunction
  task automatic op(logic sm);
    na = 20'($random(seed));
    nm = 12'($random(seed));
    ns = 10'($random(seed));
    na[7] = na[7] & na[1];
    nm[4] = nm[4] & nm[1];
    nm[5] = nm[5] & nm[1];
    alu <= na;
    mul <= nm;
    sh <= ns;
    simd_en <= sm;
    ev = upd(0);
    if (sm) ev |= upd(1);
    for (int i = 0; i < 4; i++) exp_hits[i] += int'(ev[i] & exc_enable[i]);
    @(posedge clk_i);
    alu <= '0;
    mul <= '0;
    sh <= '0;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rdchk(i);
    bus(1'b0, 4'h2, 32'h0, 4'hF);
    check("unmapped read", 32'h0, q);
    bus(1'b1, 4'h6, 32'hFFFF_FFFF, 4'hF);
    for (int ph = 0; ph < 2; ph++) begin
      exc_enable <= ph ? 4'hF : 4'($random(seed));
      @(posedge clk_i);
      repeat (300) begin
        op(1'($random(seed)));
        rdchk(2'($random(seed)));
      end
      for (int i = 0; i < 4; i++) rdchk(i);
      for (int i = 0; i < 4; i++) check("exception count", exp_hits[i], 32'(hits[i]));
    end
    na = '0;
    na[0][0] = 1'b1;
    na[4][0] = 1'b1;
    na[5][0] = 1'b1;
    fork
      wr(0, 32'hA5C3_0F11, 4'hF);
      begin
        @(posedge clk_i);
        alu <= na;
        @(posedge clk_i);
        alu <= '0;
      end
    join
    rdchk(0);
    wr(2, 32'h0, 4'h1);
    rdchk(2);
    wr(2, 32'h0, 4'hF);
    wr(3, 32'h0, 4'hF);
    rdchk(2);
    rdchk(3);
    conclude();
  end
endmodule
